// ===== core/ebac_ctrl.v
// eeprom byte access controller: cpu-side registers, strobes and timing
`include "ebac_map.vh"
module ebac_ctrl #(
   parameter AW = `EBAC_ADDR_W,
   parameter DEPTH = `EBAC_DEPTH,
   parameter T_ATOMIC = `EBAC_T_ATOMIC_US * `EBAC_TICK_PER_US,
   parameter T_SPLIT = `EBAC_T_SPLIT_US * `EBAC_TICK_PER_US
) (
   input wire i_clk,
   input wire i_arst_n,
   input wire i_ce,
   input wire i_osc_tick,
   // cpu register write strobes and their data
   input wire i_addr_we,
   input wire [AW-1:0] i_addr_wdata,
   input wire i_data_we,
   input wire [7:0] i_data_wdata,
   input wire i_mode_we,
   input wire [1:0] i_mode_wdata,
   input wire i_irq_en_we,
   input wire i_irq_en_wdata,
   // software control strobes, one cycle each, and the global interrupt enable level
   input wire i_arm_set,
   input wire i_prog_set,
   input wire i_read_set,
   input wire i_global_irq_en,
   // cpu-visible registers and status levels
   output reg [AW-1:0] o_byte_address_reg,
   output reg [7:0] o_byte_data_reg,
   output reg [1:0] o_program_mode_sel,
   output reg o_ready_irq_enable,
   output reg o_master_arm,
   output reg o_program_strobe,
   output reg o_cpu_stall,
   output reg o_ready_irq
);
   // sequencer states:
   // idle waits for an armed program strobe or a read strobe,
   // read holds the cpu while the stored byte travels to the data register,
   // prog waits for the oscillator ticks of the selected duration,
   // done refuses reads for one cycle before the next access; an armed program start is not refused there
   localparam ST_IDLE = 2'h0;
   localparam ST_READ = 2'h1;
   localparam ST_PROG = 2'h2;
   localparam ST_DONE = 2'h3;

   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [2:0] arm_cnt_q;
   reg [2:0] stall_cnt_q;
   reg [12:0] tick_cnt_q;
   reg [1:0] op_q;
   reg rst_sync_q;
   reg rst_mode_pend_q;
   wire [7:0] mem_rdata;
   wire arm_live;
   wire start_prog;
   wire start_read;
   wire prog_done;
   wire busy;
   reg mem_we;
   reg [7:0] mem_wdata;
   wire mem_re;
   wire read_load;
   wire arm_expire;
   wire ready_now;

   assign busy = o_program_strobe;
   assign arm_live = o_master_arm;
   // mode 11 is reserved and starts nothing
   assign start_prog = i_prog_set && arm_live && !busy
      && (o_program_mode_sel != `EBAC_MODE_RSVD); // see [RULE_04] [RULE_07] [RULE_08]
   assign start_read = i_read_set && !busy && (state_q == ST_IDLE); // see [RULE_06] [RULE_13]
   assign prog_done = (state_q == ST_PROG) && i_osc_tick
      && (tick_cnt_q == 13'h0001); // see [RULE_11]
   // a program start also fetches the old byte, so write-only merges into the real cell;
   // the address is locked and reads are refused while busy, so the fetch stays valid
   assign mem_re = start_read || start_prog;

   // storage array, read data registered inside
   ebac_mem #(
      .AW(AW),
      .DEPTH(DEPTH)
   ) u_mem (
      .i_clk(i_clk),
      .i_ce(i_ce),
      .i_we(mem_we),
      .i_addr(o_byte_address_reg),
      .i_wdata(mem_wdata),
      .i_re(mem_re),
      .o_rdata(mem_rdata)
   );

   // cell write at end of programming; erase leaves all ones
   always @* begin
      mem_we = prog_done; // see [RULE_04]
      if (op_q == `EBAC_MODE_ERASE) begin
         mem_wdata = `EBAC_ERASED_BYTE; // see [RULE_07]
      end else if (op_q == `EBAC_MODE_WRITE) begin
         // write-only can only clear bits; unerased cells end up corrupt
         mem_wdata = mem_rdata & o_byte_data_reg; // see [RULE_08] [RULE_09]
      end else begin
         mem_wdata = o_byte_data_reg;
      end
   end

   // next state of the access sequencer; a program start outranks a read
   // in the same cycle, and done always returns to idle after one cycle
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (start_prog) begin
               state_d = ST_PROG;
            end else if (start_read) begin
               state_d = ST_READ;
            end
         end
         ST_READ: begin
            if (stall_cnt_q == 3'h1) begin
               state_d = ST_IDLE;
            end
         end
         ST_PROG: begin
            if (prog_done) begin
               state_d = ST_DONE;
            end
         end
         ST_DONE: begin
            state_d = ST_IDLE;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // reset release marker: reset clears the mode at once; the marker drops on the same edge that sets rst_sync_q, so it never clears the mode again
   // limitation: the asynchronous reset also ends a running operation,
   // so software must not reset during programming if the byte matters
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_sync_q <= 1'b0;
         rst_mode_pend_q <= 1'b1;
      end else if (i_ce) begin
         rst_sync_q <= 1'b1;
         if (rst_mode_pend_q && !busy) begin
            rst_mode_pend_q <= 1'b0;
         end
      end
   end

   // read data are taken once the array's registered output has settled
   assign read_load = (state_q == ST_READ) && (stall_cnt_q == `EBAC_READ_STALL - 3'h1);
   // the arm window closes on the fourth cycle after it was opened
   assign arm_expire = (arm_cnt_q == 3'h1); // see [RULE_19]
   // idle means nothing is starting, running or finishing in the array
   assign ready_now = !(busy || start_prog) && (state_q != ST_PROG); // see [RULE_18]

   // sequencer state register
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_q <= ST_IDLE;
      end else if (i_ce) begin
         state_q <= state_d;
      end
   end

   // address register; locked while busy so the cell being programmed cannot move
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_byte_address_reg <= {AW{1'b0}};
      end else if (i_ce) begin
         if (i_addr_we && !busy) begin
            o_byte_address_reg <= i_addr_wdata; // see [RULE_14] [RULE_06]
         end
      end
   end

   // data register: a read's result wins over a cpu write in the same cycle
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_byte_data_reg <= `EBAC_DATA_RST;
      end else if (i_ce) begin
         if (read_load) begin
            o_byte_data_reg <= mem_rdata; // see [RULE_13]
         end else if (i_data_we && !busy && state_q != ST_READ) begin
            o_byte_data_reg <= i_data_wdata; // see [RULE_14]
         end
      end
   end

   // mode field: frozen while the strobe is set
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_program_mode_sel <= `EBAC_MODE_ATOMIC; // see [RULE_17]
      end else if (i_ce) begin
         if (rst_mode_pend_q && !busy && rst_sync_q) begin
            o_program_mode_sel <= `EBAC_MODE_ATOMIC; // see [RULE_17]
         end else if (i_mode_we && !busy) begin
            o_program_mode_sel <= i_mode_wdata; // see [RULE_16]
         end
      end
   end

   // ready interrupt enable, writable at any time
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_ready_irq_enable <= 1'b0;
      end else if (i_ce) begin
         if (i_irq_en_we) begin
            o_ready_irq_enable <= i_irq_en_wdata;
         end
      end
   end

   // arm bit opens a four-cycle window then clears itself
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         arm_cnt_q <= 3'h0;
         o_master_arm <= 1'b0;
      end else if (i_ce) begin
         if (i_arm_set) begin
            o_master_arm <= 1'b1;
            arm_cnt_q <= `EBAC_ARM_WINDOW;
         end else if (start_prog) begin
            // a used arm cannot start a second operation
            o_master_arm <= 1'b0;
            arm_cnt_q <= 3'h0;
         end else if (arm_cnt_q != 3'h0) begin
            arm_cnt_q <= arm_cnt_q - 3'h1;
            if (arm_expire) begin
               o_master_arm <= 1'b0; // see [RULE_19]
            end
         end
      end
   end

   // programming start and end; duration counts oscillator ticks, not cpu cycles,
   // and the mode is latched so the cell write matches what was started
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_program_strobe <= 1'b0;
         op_q <= `EBAC_MODE_ATOMIC;
         tick_cnt_q <= 13'h0000;
      end else if (i_ce) begin
         if (start_prog) begin
            o_program_strobe <= 1'b1; // see [RULE_05]
            op_q <= o_program_mode_sel;
            if (o_program_mode_sel == `EBAC_MODE_ATOMIC) begin
               tick_cnt_q <= T_ATOMIC[12:0]; // see [RULE_15]
            end else begin
               tick_cnt_q <= T_SPLIT[12:0]; // see [RULE_15]
            end
         end else if (state_q == ST_PROG && i_osc_tick && tick_cnt_q != 13'h0000) begin
            tick_cnt_q <= tick_cnt_q - 13'h0001; // see [RULE_10]
         end
         if (prog_done) begin
            o_program_strobe <= 1'b0; // see [RULE_05] [RULE_11]
         end
      end
   end

   // cpu halt: two cycles for a program start, four for a read
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         stall_cnt_q <= 3'h0;
         o_cpu_stall <= 1'b0;
      end else if (i_ce) begin
         if (start_prog) begin
            stall_cnt_q <= `EBAC_PROG_STALL;
            o_cpu_stall <= 1'b1; // see [RULE_03]
         end else if (start_read) begin
            stall_cnt_q <= `EBAC_READ_STALL;
            o_cpu_stall <= 1'b1; // see [RULE_02]
         end else if (stall_cnt_q != 3'h0) begin
            stall_cnt_q <= stall_cnt_q - 3'h1;
            if (stall_cnt_q == 3'h1) begin
               o_cpu_stall <= 1'b0;
            end
         end
      end
   end

   // level interrupt, present whenever the array is idle and both enables are set;
   // registered, so it returns one cycle after the busy bit clears; start_prog drops it on the same edge that sets busy
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_ready_irq <= 1'b0;
      end else if (i_ce) begin
         o_ready_irq <= o_ready_irq_enable && i_global_irq_en && ready_now; // see [RULE_18]
      end
   end
endmodule

// ===== core/ebac_map.vh
// constants and timing counts for the eeprom byte access controller
// What this block does
// [RULE_01] byte storage of 128, 256 or 512 bytes
// [RULE_02] read stalls the cpu four cycles
// [RULE_03] program start stalls the cpu two cycles
// [RULE_04] mode zero, strobe after arm: erase plus write
// [RULE_05] program strobe stays set while programming
// [RULE_06] no other operation while programming is busy
// [RULE_07] mode 01 with arm: erase the byte only
// [RULE_08] mode 10 with arm: write without erase
// [RULE_09] software erases before a write-only operation
// [RULE_10] programming time paced by calibrated oscillator
// [RULE_11] self-timed, completion visible to software
// [RULE_12] software polls strobe clear before new access
// [RULE_13] read strobe loads stored byte into data
// [RULE_14] address, data, control reachable as cpu registers
// [RULE_15] 3.4 ms combined, 1.8 ms split, 11 reserved
// [RULE_16] mode writes ignored while strobe is set
// [RULE_17] reset clears mode unless programming in progress; here the asynchronous reset clears the mode at once and ends programming
// [RULE_18] ready interrupt level while not busy, when enabled
// [RULE_19] arm bit self-clears four cycles after set
`ifndef EBAC_MAP_VH
`define EBAC_MAP_VH
`define EBAC_ADDR_W 9
`define EBAC_DEPTH 512
`define EBAC_MODE_ATOMIC 2'h0
`define EBAC_MODE_ERASE 2'h1
`define EBAC_MODE_WRITE 2'h2
`define EBAC_MODE_RSVD 2'h3
`define EBAC_READ_STALL 3'h4
`define EBAC_PROG_STALL 3'h2
`define EBAC_ARM_WINDOW 3'h4
`define EBAC_ERASED_BYTE 8'hff
`define EBAC_DATA_RST 8'h00
// oscillator ticks assumed 1 per microsecond; times in microseconds
`define EBAC_T_ATOMIC_US 3400
`define EBAC_T_SPLIT_US 1800
`define EBAC_TICK_PER_US 1
`endif

// ===== core/ebac_mem.v
// byte-wide storage array with registered read data
module ebac_mem #(
   parameter AW = 9,
   parameter DEPTH = 512
) (
   input wire i_clk,
   input wire i_ce,
   input wire i_we,
   input wire [AW-1:0] i_addr,
   input wire [7:0] i_wdata,
   input wire i_re,
   output reg [7:0] o_rdata
);
   reg [7:0] mem [0:DEPTH-1];

   // no reset on cells: they are the nonvolatile contents
   always @(posedge i_clk) begin
      if (i_ce) begin
         if (i_we) begin
            mem[i_addr] <= i_wdata; // see [RULE_01]
         end
         if (i_re) begin
            o_rdata <= mem[i_addr];
         end
      end
   end
endmodule

// ===== test/ebac_osc_model.sv
// calibrated oscillator stand-in driving the programming time base
module ebac_osc_model #(parameter DIV = 3) (
   input wire logic i_clk,
   input wire logic i_arst_n,
   output logic o_tick
);
   timeunit 1ns;
   timeprecision 1ns;
   integer cnt_q;
   // free-running divider, so the tick phase is unrelated to any request
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cnt_q <= 0;
         o_tick <= 1'b0;
      end else begin
         cnt_q <= (cnt_q == DIV - 1) ? 0 : cnt_q + 1;
         o_tick <= (cnt_q == DIV - 1);
      end
   end
endmodule

// ===== test/ebac_ctrl_sva.sv
// port-level assertions for the eeprom byte access controller
module ebac_ctrl_sva #(parameter AW = 9) (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_ce,
   input wire logic i_prog_set,
   input wire logic i_read_set,
   input wire logic i_global_irq_en,
   input wire logic [AW-1:0] o_byte_address_reg,
   input wire logic [7:0] o_byte_data_reg,
   input wire logic [1:0] o_program_mode_sel,
   input wire logic o_ready_irq_enable,
   input wire logic o_master_arm,
   input wire logic o_program_strobe,
   input wire logic o_cpu_stall,
   input wire logic o_ready_irq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   // arm, start and refusal
   a_arm_lapse: assert property ($rose(o_master_arm) |-> ##4 !o_master_arm)
      else $error("arm bit did not lapse");
   a_prog_start: assert property (i_ce && i_prog_set && o_master_arm && !o_program_strobe
      && o_program_mode_sel != 2'h3 |=> o_program_strobe && o_cpu_stall && !o_master_arm)
      else $error("armed strobe did not start");
   a_unarmed_none: assert property (i_prog_set && !o_master_arm && !o_program_strobe
      |=> !o_program_strobe) else $error("unarmed strobe started");
   a_rsvd_none: assert property (i_prog_set && o_program_mode_sel == 2'h3
      && !o_program_strobe |=> !o_program_strobe) else $error("reserved mode started");
   // cpu halt lengths
   a_prog_halt: assert property ($rose(o_program_strobe) |-> o_cpu_stall [*2] ##1 !o_cpu_stall)
      else $error("program halt length wrong");
   a_read_halt: assert property (i_ce && i_read_set && !o_program_strobe && !o_cpu_stall
      |=> o_cpu_stall [*4] ##1 !o_cpu_stall) else $error("read halt length wrong");
   // registers frozen while busy
   a_mode_hold: assert property (o_program_strobe |=> $stable(o_program_mode_sel))
      else $error("mode changed while busy");
   a_regs_hold: assert property (o_program_strobe |=> $stable(o_byte_address_reg)
      && $stable(o_byte_data_reg)) else $error("address or data changed while busy");
   // ready interrupt level
   a_busy_quiet: assert property (o_program_strobe |-> !o_ready_irq)
      else $error("ready irq while busy");
   a_ready_back: assert property ($fell(o_program_strobe) && o_ready_irq_enable
      && i_global_irq_en |=> o_ready_irq) else $error("ready irq missing after done");
endmodule

bind ebac_ctrl ebac_ctrl_sva #(.AW(AW)) u_sva (.i_clk, .i_arst_n, .i_ce, .i_prog_set,
   .i_read_set, .i_global_irq_en, .o_byte_address_reg, .o_byte_data_reg,
   .o_program_mode_sel, .o_ready_irq_enable, .o_master_arm, .o_program_strobe,
   .o_cpu_stall, .o_ready_irq);

// ===== test/test_eeprom_byte_access_ctrl.sv
// self-checking bench for the eeprom byte access controller
module test_eeprom_byte_access_ctrl;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_n, ce, tick, awe, dwe, mwe, iwe, iwd, arm, prg, rd, gie;
   logic [8:0] aw, a_q, a;
   logic [7:0] dw, d_q, d;
   logic [1:0] mw, m_q;
   logic ie_q, arm_q, busy, stall, irq;
   logic [31:0] r;
   logic [7:0] mem [0:511];
   integer fail_count = 0, n_tests = 0, seed = 32'h2e05ece2, ticks = 0, k;

   ebac_osc_model #(.DIV(3)) osc (.i_clk(clk), .i_arst_n(rst_n), .o_tick(tick));
   // short programming counts keep the run brief
   ebac_ctrl #(.T_ATOMIC(8), .T_SPLIT(4)) dut (.i_clk(clk), .i_arst_n(rst_n), .i_ce(ce),
      .i_osc_tick(tick), .i_addr_we(awe), .i_addr_wdata(aw), .i_data_we(dwe),
      .i_data_wdata(dw), .i_mode_we(mwe), .i_mode_wdata(mw), .i_irq_en_we(iwe),
      .i_irq_en_wdata(iwd), .i_arm_set(arm), .i_prog_set(prg), .i_read_set(rd),
      .i_global_irq_en(gie), .o_byte_address_reg(a_q), .o_byte_data_reg(d_q),
      .o_program_mode_sel(m_q), .o_ready_irq_enable(ie_q), .o_master_arm(arm_q),
      .o_program_strobe(busy), .o_cpu_stall(stall), .o_ready_irq(irq));

   initial begin
      clk = 0;
      forever #50 clk = ~clk;
   end
   // ticks seen while busy give the programming length
   always @(posedge clk) if (busy === 1'b1 && tick) ticks <= ticks + 1;

   task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic load(input [8:0] ad, input [7:0] da, input [1:0] mo);
      @(posedge clk);
      {awe, dwe, mwe} <= 3'h7; aw <= ad; dw <= da; mw <= mo;
      @(posedge clk);
      {awe, dwe, mwe} <= 3'h0;
      #1;
   endtask
   // full programming sequence; a gap of 5 misses the arm window
   task automatic op(input [8:0] ad, input [7:0] da, input [1:0] mo, input integer g);
      integer j;
      logic ok;
      ok = (mo != 2'h3) && g < 5;
      load(ad, da, mo);
      @(posedge clk) arm <= 1;
      @(posedge clk) arm <= 0;
      repeat (g - 1) @(posedge clk);
      prg <= 1;
      ticks = 0;
      @(posedge clk) prg <= 0;
      #1;
      chk(busy, ok);
      if (ok) begin
         load(~ad, ~da, 2'h3);
         chk(m_q, mo);
         chk(a_q, ad);
         chk(d_q, da);
         for (j = 0; j < 200 && busy === 1'b1; j++) @(posedge clk) #1;
         chk(ticks, mo == 2'h0 ? 8 : 4);
         @(posedge clk) #1;
         chk(irq, gie);
         mem[ad] = mo == 2'h0 ? da : mo == 2'h1 ? 8'hff : mem[ad] & da;
      end
   endtask
   task automatic rdchk(input [8:0] ad);
      @(posedge clk) begin awe <= 1; aw <= ad; end
      @(posedge clk) begin awe <= 0; rd <= 1; end
      @(posedge clk) rd <= 0;
      repeat (2) @(posedge clk);
      #1;
      chk(d_q, mem[ad]);
      repeat (4) @(posedge clk);
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // hang guard, well beyond the expected run of under a thousand cycles
   initial begin
      #2000000;
      fail_count++;
      tally_and_finish;
   end
   initial begin
      {rst_n, awe, dwe, mwe, iwe, arm, prg, rd, aw, dw, mw} = 0;
      {ce, iwd, gie} = 3'h7;
      repeat (3) @(posedge clk);
      rst_n <= 1;
      @(posedge clk) iwe <= 1;
      @(posedge clk) iwe <= 0;
      #1;
      chk(busy, 0);
      chk(m_q, 0);
      chk(d_q, 0);
      chk(ie_q, 1);
      // clock enable low freezes every register, writes included
      @(posedge clk) begin ce <= 0; awe <= 1; aw <= 9'h1a5; end
      repeat (2) @(posedge clk);
      #1;
      chk(a_q, 9'h000);
      @(posedge clk) begin ce <= 1; awe <= 0; end
      for (k = 0; k < 16; k++) begin
         r = $random(seed);
         a = r[8:0];
         d = r[16:9];
         @(posedge clk) gie <= r[20];
         op(a, 8'h00, 2'h1, 1);
         op(a, d, k[1:0], 1 + k % 5);
         rdchk(a);
         $display("test %0d done", k);
      end
      tally_and_finish;
   end
endmodule
